// >>> core_model.sv
/*
 * Processor core model: signals interrupt entry once a request line has
 * stayed low for lat cycles, so entry can be prompt or slow.
 * Assumes active-low request lines that change on ref_clk.
 */
`timescale 1ns/1ps
module core_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic normal_irq_request_n,
    input wire logic fast_irq_request_n,
    input wire logic [3:0] lat,
    output logic irq_taken,
    output logic fiq_taken
);
    logic [3:0] irq_cnt;
    logic [3:0] fiq_cnt;
    // *****
    // entry latency
    // *****
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_cnt <= 4'h0;
            fiq_cnt <= 4'h0;
        end else begin
            irq_cnt <= normal_irq_request_n ? 4'h0 : (irq_cnt < lat ? irq_cnt + 4'h1 : lat);
            fiq_cnt <= fast_irq_request_n ? 4'h0 : (fiq_cnt < lat ? fiq_cnt + 4'h1 : lat);
        end
    end
    // entry ends as soon as the line is released
    assign irq_taken = !normal_irq_request_n && irq_cnt >= lat;
    assign fiq_taken = !fast_irq_request_n && fiq_cnt >= lat;
endmodule

// >>> irq_ctl_pkg.sv
/*
 * Constants, register offsets, field layouts and carrier types of the
 * vectored interrupt controller.
 * Assumes a 12-bit APB byte address within the controller's 4 KB window.
 */
// Behaviour
// - normal vector read makes highest pending enabled source current; its priority is level
// - normal vector read drops the normal request; software must read it to release
// - normal vector read clears the chosen source's pending bit when edge-triggered
// - normal vector read pushes current level and interrupt number on the stack unless all 8 entries are full
// - normal vector read returns the chosen source's stored handler address
// - normal request reasserts when an enabled source above current level pends
// - end-of-interrupt write pops the stack; request reasserts if a pending source exceeds it
// - only source 0 raises the fast request unless forcing redirects others
// - source 0 priority is ignored for arbitration but reads back as written
// - source 0 trigger type picks rising, falling, high or low
// - enable and disable command bit 0 set and clear fast enable, shown in mask bit 0
// - fast vector read at offset 0x104 returns source 0 vector
// - fast vector read clears source 0 only when edge-triggered, dropping the line
// - force enable and disable writes set and clear bits of force status
// - forced source keeps detection, never raises normal request, skips arbitration
// - forced source raises fast request on active level or detected edge
// - forcing leaves source 0 pending bit untouched
// - fast vector read always returns source 0 vector; with forcing it does not clear source 0
// - normal vector read never clears a force-enabled source
// - source 0 stays a fast contributor alongside forced sources
package irq_ctl_pkg;
    localparam int NSRC = 32;
    localparam int STK_D = 8;
    localparam logic [3:0] DEPTH_FULL = 4'h8;
    localparam logic [31:0] NRM_MASK = 32'hFFFF_FFFE;
    // source mode layout
    localparam int PRIO_LSB = 0;
    localparam int TYPE_LSB = 5;
    localparam logic [1:0] T_LOW = 2'h0;
    localparam logic [1:0] T_FALL = 2'h1;
    localparam logic [1:0] T_HIGH = 2'h2;
    localparam logic [1:0] T_RISE = 2'h3;
    // register offsets
    localparam logic [4:0] BLK_SMR = 5'h00;
    localparam logic [4:0] BLK_SVR = 5'h01;
    localparam logic [11:0] OFS_IVR = 12'h100;
    localparam logic [11:0] OFS_FVR = 12'h104;
    localparam logic [11:0] OFS_ISR = 12'h108;
    localparam logic [11:0] OFS_IPR = 12'h10C;
    localparam logic [11:0] OFS_IMR = 12'h110;
    localparam logic [11:0] OFS_CISR = 12'h114;
    localparam logic [11:0] OFS_IECR = 12'h120;
    localparam logic [11:0] OFS_IDCR = 12'h124;
    localparam logic [11:0] OFS_ICCR = 12'h128;
    localparam logic [11:0] OFS_ISCR = 12'h12C;
    localparam logic [11:0] OFS_EOICR = 12'h130;
    localparam logic [11:0] OFS_FFER = 12'h140;
    localparam logic [11:0] OFS_FFDR = 12'h144;
    localparam logic [11:0] OFS_FFSR = 12'h148;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [2:0] lvl;
        logic [4:0] num;
    } stk_ent_t;

    typedef struct packed {
        logic [NSRC-1:0][31:0] svr;
        logic [NSRC-1:0][2:0] prio;
        logic [NSRC-1:0][1:0] stype;
        logic [NSRC-1:0] imr;
        logic [NSRC-1:0] ffsr;
        logic [NSRC-1:0] edge_pend;
        logic [NSRC-1:0] src_q;
        logic [NSRC-1:0] src_prev;
        logic [STK_D-1:0][7:0] stk;
        logic [3:0] depth;
        apb_rsp_t rsp;
        logic irq_n;
        logic fiq_n;
    } ctl_state_t;
endpackage

// >>> test_vectored_irq_controller.sv
/*
 * Self-checking bench of the vectored interrupt controller: APB master,
 * source stimulus and a core model on the request lines.
 * Assumes the one-wait-state APB slave and request latencies of the note.
 */
`timescale 1ns/1ps
module test_vectored_irq_controller;
    import irq_ctl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    apb_req_t apb_req = '0;
    apb_rsp_t apb_rsp;
    logic [31:0] irq_src = 32'h0000_0000;
    logic normal_irq_request_n;
    logic fast_irq_request_n;
    logic [3:0] lat = 4'h0;
    logic irq_taken;
    logic fiq_taken;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_0056;
    logic [31:0] q;
    logic err;
    logic [31:0] r;
    logic [31:0] v0;
    logic [31:0] v3;
    logic [31:0] v5;
    logic [31:0] v7;
    vectored_irq_controller vectored_irq_controller_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .irq_src(irq_src),
        .normal_irq_request_n(normal_irq_request_n), .fast_irq_request_n(fast_irq_request_n));
    core_model core_model_inst (.ref_clk(ref_clk), .reset_n(reset_n), .lat(lat),
        .normal_irq_request_n(normal_irq_request_n), .fast_irq_request_n(fast_irq_request_n),
        .irq_taken(irq_taken), .fiq_taken(fiq_taken));
    // *****
    // helpers
    // *****
    function automatic logic [31:0] smr(input logic [2:0] p, input logic [1:0] t);
        return {25'h0, t, 2'h0, p};
    endfunction
    function automatic logic [11:0] smr_a(input logic [4:0] n);
        return {5'h00, n, 2'h0};
    endfunction
    function automatic logic [11:0] svr_a(input logic [4:0] n);
        return {5'h01, n, 2'h0};
    endfunction
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic summarize();
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        q = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        check("pready", {31'h0, apb_rsp.pready}, 32'h1);
    endtask
    task automatic src(input int n, input logic v);
        @(posedge ref_clk);
        irq_src[n] <= v;
    endtask
    task automatic lines(input logic en, input logic ef);
        @(posedge ref_clk);
        check("normal_line", {31'h0, normal_irq_request_n}, {31'h0, en});
        check("fast_line", {31'h0, fast_irq_request_n}, {31'h0, ef});
    endtask
    task automatic wait_take(input logic fast);
        int k;
        k = 0;
        while ((fast ? fiq_taken : irq_taken) !== 1'b1 && k < 40) begin
            @(posedge ref_clk);
            k++;
        end
        check("take", {31'h0, fast ? fiq_taken : irq_taken}, 32'h1);
    endtask
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    // *****
    // scenarios
    // *****
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        lines(1'b1, 1'b1);
        apb(1'b0, OFS_IMR, 0);
        check("imr_reset", q, RST_WORD);
        apb(1'b0, OFS_FFSR, 0);
        check("ffsr_reset", q, RST_WORD);
        apb(1'b0, 12'h118, 0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_data", q, 32'h0);
        v3 = xorshift();
        v5 = xorshift();
        v7 = xorshift();
        apb(1'b1, smr_a(3), smr(3'h2, T_RISE));
        apb(1'b1, svr_a(3), v3);
        apb(1'b1, smr_a(5), smr(3'h5, T_HIGH));
        apb(1'b1, svr_a(5), v5);
        apb(1'b1, smr_a(7), smr(3'h1, T_RISE));
        apb(1'b1, svr_a(7), v7);
        apb(1'b1, OFS_IECR, 32'h0000_00A8);
        lat <= 4'h3;
        src(3, 1'b1);
        wait_take(1'b0);
        apb(1'b0, OFS_IVR, 0);
        check("ivr_src3", q, v3);
        lines(1'b1, 1'b1);
        apb(1'b0, OFS_IPR, 0);
        check("ipr_src3", {31'h0, q[3]}, 32'h0);
        apb(1'b0, OFS_ISR, 0);
        check("isr_src3", q, 32'h3);
        src(3, 1'b0);
        lat <= 4'h0;
        src(5, 1'b1);
        wait_take(1'b0);
        apb(1'b0, OFS_IVR, 0);
        check("ivr_src5", q, v5);
        src(5, 1'b0);
        src(7, 1'b1);
        repeat (4) @(posedge ref_clk);
        lines(1'b1, 1'b1);
        apb(1'b1, OFS_EOICR, 0);
        apb(1'b0, OFS_ISR, 0);
        check("isr_pop", q, 32'h3);
        lines(1'b1, 1'b1);
        apb(1'b1, OFS_EOICR, 0);
        wait_take(1'b0);
        apb(1'b0, OFS_IVR, 0);
        check("ivr_src7", q, v7);
        src(7, 1'b0);
        apb(1'b1, OFS_EOICR, 0);
        lines(1'b1, 1'b1);
        v0 = xorshift();
        apb(1'b1, svr_a(0), v0);
        for (int t = 0; t < 4; t++) begin
            logic [1:0] ty;
            ty = 2'(t);
            r = xorshift();
            src(0, ~ty[1]);
            apb(1'b1, smr_a(0), smr(r[2:0], ty));
            apb(1'b0, smr_a(0), 0);
            check("smr0", q, smr(r[2:0], ty));
            apb(1'b1, OFS_ICCR, 32'h1);
            apb(1'b1, OFS_IECR, 32'h1);
            apb(1'b0, OFS_IMR, 0);
            check("imr_on", {31'h0, q[0]}, 32'h1);
            lines(1'b1, 1'b1);
            src(0, ty[1]);
            wait_take(1'b1);
            apb(1'b0, OFS_FVR, 0);
            check("fvr", q, v0);
            lines(1'b1, ty[0]);
            src(0, ~ty[1]);
            repeat (4) @(posedge ref_clk);
            lines(1'b1, 1'b1);
            apb(1'b1, OFS_IDCR, 32'h1);
            apb(1'b0, OFS_IMR, 0);
            check("imr_off", {31'h0, q[0]}, 32'h0);
        end
        apb(1'b1, smr_a(9), smr(3'h6, T_RISE));
        apb(1'b1, OFS_IECR, 32'h0000_0201);
        apb(1'b1, OFS_FFER, 32'h0000_0201);
        apb(1'b0, OFS_FFSR, 0);
        check("ffsr_set", q, 32'h0000_0200);
        src(9, 1'b1);
        wait_take(1'b1);
        lines(1'b1, 1'b0);
        src(0, 1'b1);
        repeat (4) @(posedge ref_clk);
        apb(1'b0, OFS_IVR, 0);
        check("ivr_forced", q, 32'h0);
        apb(1'b0, OFS_FVR, 0);
        check("fvr_forced", q, v0);
        apb(1'b0, OFS_IPR, 0);
        check("ipr_forced", q & 32'h0000_0201, 32'h0000_0201);
        apb(1'b1, OFS_ICCR, 32'h0000_0200);
        lines(1'b1, 1'b0);
        apb(1'b0, OFS_CISR, 0);
        check("cisr_fast", q, 32'h0000_0001);
        apb(1'b1, OFS_ICCR, 32'h1);
        lines(1'b1, 1'b1);
        src(9, 1'b0);
        src(0, 1'b0);
        apb(1'b1, OFS_FFDR, 32'h0000_0200);
        apb(1'b0, OFS_FFSR, 0);
        check("ffsr_clr", q, 32'h0);
        summarize();
    end
endmodule

// >>> vectored_irq_controller.sv
/*
 * Vectored interrupt controller: 32 sources, eight-level priority stack,
 * normal and fast request lines toward the core, APB register access.
 * Assumes source inputs synchronous to ref_clk and an APB master that
 * holds each request until pready.
 */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module vectored_irq_controller (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire irq_ctl_pkg::apb_req_t apb_req,
    output irq_ctl_pkg::apb_rsp_t apb_rsp,
    input wire logic [31:0] irq_src,
    output logic normal_irq_request_n,
    output logic fast_irq_request_n
);
    import irq_ctl_pkg::*;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic is_edge(input logic [1:0] t);
        is_edge = (t == T_FALL) || (t == T_RISE);
    endfunction

    function automatic logic src_hit(input logic [1:0] t, input logic cur,
                                     input logic prev);
        unique case (t)
            T_LOW: src_hit = !cur;
            T_FALL: src_hit = prev && !cur;
            T_HIGH: src_hit = cur;
            T_RISE: src_hit = !prev && cur;
        endcase
    endfunction

    ctl_state_t s;
    ctl_state_t n;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] edge_hit;
    logic [NSRC-1:0] cand;
    logic found;
    logic [2:0] bprio;
    logic [4:0] bidx;
    logic above;
    logic fiq_line;
    logic acc;
    stk_ent_t top;

    // ****************************************
    // per-source detection
    // ****************************************
    for (genvar gi = 0; gi < NSRC; gi++) begin : g_src
        // forced sources keep this detection too
        assign edge_hit[gi] = is_edge(s.stype[gi])
            && src_hit(s.stype[gi], s.src_q[gi], s.src_prev[gi]);
        assign pend[gi] = is_edge(s.stype[gi]) ? s.edge_pend[gi]
            : src_hit(s.stype[gi], s.src_q[gi], s.src_prev[gi]);
    end

    // ****************************************
    // arbitration
    // ****************************************
    // source 0 and forced sources never compete
    assign cand = pend & s.imr & ~s.ffsr & NRM_MASK;
    assign top = s.stk[0];

    always_comb begin
        found = 1'b0;
        bprio = 3'h0;
        bidx = 5'h00;
        for (int i = NSRC - 1; i >= 0; i--) begin
            // ties go to the lowest source number
            if (cand[i] && (!found || s.prio[i] >= bprio)) begin
                found = 1'b1;
                bprio = s.prio[i];
                bidx = 5'(i);
            end
        end
    end

    assign above = found && (s.depth == 4'h0 || bprio > top.lvl);
    assign fiq_line = (s.imr[0] && pend[0])
        || |(pend & s.imr & s.ffsr & NRM_MASK);
    // taken only in the first access cycle, before pready rises
    assign acc = apb_req.psel && apb_req.penable && !s.rsp.pready;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = s;
        n.rsp.pready = 1'b0;
        n.rsp.pslverr = 1'b0;
        n.src_q = irq_src;
        n.src_prev = s.src_q;
        if (acc) begin
            n.rsp.pready = 1'b1;
            n.rsp.prdata = RST_WORD;
            if (apb_req.paddr[11:7] == BLK_SMR) begin
                if (apb_req.pwrite) begin
                    n.prio[apb_req.paddr[6:2]] = apb_req.pwdata[PRIO_LSB +: 3];
                    n.stype[apb_req.paddr[6:2]] = apb_req.pwdata[TYPE_LSB +: 2];
                end else begin
                    n.rsp.prdata[PRIO_LSB +: 3] = s.prio[apb_req.paddr[6:2]];
                    n.rsp.prdata[TYPE_LSB +: 2] = s.stype[apb_req.paddr[6:2]];
                end
            end else if (apb_req.paddr[11:7] == BLK_SVR) begin
                if (apb_req.pwrite) begin
                    n.svr[apb_req.paddr[6:2]] = apb_req.pwdata;
                end else begin
                    n.rsp.prdata = s.svr[apb_req.paddr[6:2]];
                end
            end else if (apb_req.pwrite) begin
                unique case (apb_req.paddr)
                    OFS_IECR: n.imr = s.imr | apb_req.pwdata;
                    OFS_IDCR: n.imr = s.imr & ~apb_req.pwdata;
                    OFS_ICCR: n.edge_pend = s.edge_pend & ~apb_req.pwdata;
                    OFS_ISCR: n.edge_pend = s.edge_pend | apb_req.pwdata;
                    OFS_EOICR: begin
                        if (s.depth != 4'h0) begin
                            n.stk = {8'h00, s.stk[STK_D-1:1]};
                            n.depth = s.depth - 4'h1;
                        end
                    end
                    OFS_FFER: n.ffsr = s.ffsr | (apb_req.pwdata & NRM_MASK);
                    OFS_FFDR: n.ffsr = s.ffsr & ~apb_req.pwdata;
                    OFS_IVR, OFS_FVR, OFS_ISR, OFS_IPR, OFS_IMR, OFS_CISR,
                    OFS_FFSR: ;
                    default: n.rsp.pslverr = 1'b1;
                endcase
            end else begin
                unique case (apb_req.paddr)
                    OFS_IVR: begin
                        if (above) begin
                            n.rsp.prdata = s.svr[bidx];
                            if (s.depth != DEPTH_FULL) begin
                                n.stk = {s.stk[STK_D-2:0], {bprio, bidx}};
                                n.depth = s.depth + 4'h1;
                            end
                            // forced sources are never chosen here
                            if (is_edge(s.stype[bidx])) begin
                                n.edge_pend[bidx] = 1'b0;
                            end
                        end
                    end
                    OFS_FVR: begin
                        n.rsp.prdata = s.svr[0];
                        if (is_edge(s.stype[0]) && !(|(s.ffsr & NRM_MASK))) begin
                            n.edge_pend[0] = 1'b0;
                        end
                    end
                    OFS_ISR: n.rsp.prdata[4:0] = (s.depth == 4'h0) ? 5'h00 : top.num;
                    OFS_IPR: n.rsp.prdata = pend;
                    OFS_IMR: n.rsp.prdata = s.imr;
                    OFS_CISR: n.rsp.prdata[1:0] = {~s.irq_n, ~s.fiq_n};
                    OFS_FFSR: n.rsp.prdata = s.ffsr;
                    OFS_IECR, OFS_IDCR, OFS_ICCR, OFS_ISCR, OFS_EOICR,
                    OFS_FFER, OFS_FFDR: ;
                    default: n.rsp.pslverr = 1'b1;
                endcase
            end
        end
        // new edges win over any clear in the same cycle
        n.edge_pend = n.edge_pend | edge_hit;
        n.irq_n = !above;
        n.fiq_n = !fiq_line;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.irq_n <= 1'b1;
            s.fiq_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign apb_rsp = s.rsp;
    assign normal_irq_request_n = s.irq_n;
    assign fast_irq_request_n = s.fiq_n;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence rd_s(logic [11:0] a);
        acc && !apb_req.pwrite && apb_req.paddr == a;
    endsequence

    sequence wr_s(logic [11:0] a);
        acc && apb_req.pwrite && apb_req.paddr == a;
    endsequence

    sequence ivr_take_s;
        rd_s(OFS_IVR) ##0 above;
    endsequence

    sequence fvr_take_s;
        rd_s(OFS_FVR);
    endsequence

    sequence eoi_pop_s;
        wr_s(OFS_EOICR) ##0 s.depth != 4'h0;
    endsequence

    sequence smr_wr_s;
        acc && apb_req.pwrite && apb_req.paddr[11:7] == BLK_SMR;
    endsequence

    sequence svr_wr_s;
        acc && apb_req.pwrite && apb_req.paddr[11:7] == BLK_SVR;
    endsequence

    AST_IVR_LEVEL: assert property (ivr_take_s ##0 s.depth != DEPTH_FULL
        |=> s.stk[0][7:5] == $past(bprio) && s.stk[0][4:0] == $past(bidx))
        else $error("current level not taken from chosen source");

    AST_IRQ_RELEASE: assert property (ivr_take_s ##1 !above |=> s.irq_n)
        else $error("normal request not released after vector read");

    AST_EDGE_CLR: assert property (ivr_take_s
        ##0 (is_edge(s.stype[bidx]) && !edge_hit[bidx])
        |=> !s.edge_pend[$past(bidx)])
        else $error("edge source not cleared by vector read");

    AST_PUSH: assert property (ivr_take_s ##0 s.depth != DEPTH_FULL
        |=> s.depth == $past(s.depth) + 4'h1 && s.stk[1] == $past(s.stk[0]))
        else $error("stack push missing");

    AST_VECTOR: assert property (ivr_take_s
        |=> s.rsp.pready && s.rsp.prdata == $past(s.svr[bidx]))
        else $error("wrong handler address returned");

    AST_NEST: assert property (above |=> !s.irq_n)
        else $error("higher source did not raise normal request");

    AST_EOI: assert property (wr_s(OFS_EOICR) ##0 s.depth != 4'h0
        |=> s.depth == $past(s.depth) - 4'h1 && s.stk[0] == $past(s.stk[1]))
        else $error("end of interrupt did not pop");

    AST_NRM_EXCL: assert property (found |-> !s.ffsr[bidx] && bidx != 5'h00)
        else $error("forced or fast source in arbitration");

    AST_FIQ_LINE: assert property (fiq_line |=> !s.fiq_n ##0 $past(fiq_line))
        else $error("fast request not raised");

    AST_IMR0: assert property (wr_s(OFS_IECR) ##0 apb_req.pwdata[0]
        |=> s.imr[0])
        else $error("fast enable not recorded");

    AST_FVR: assert property (rd_s(OFS_FVR) |=> s.rsp.prdata == $past(s.svr[0]))
        else $error("fast vector read wrong");

    AST_FF_KEEP0: assert property (rd_s(OFS_FVR) ##0 |(s.ffsr & NRM_MASK)
        ##0 s.edge_pend[0] |=> s.edge_pend[0])
        else $error("source 0 cleared while forcing in use");

    // ****************************************
    // register checks
    // ****************************************
    AST_IMR0_OFF: assert property (wr_s(OFS_IDCR) ##0 apb_req.pwdata[0]
        |=> !s.imr[0])
        else $error("fast disable not recorded");

    AST_IMR_READ: assert property (rd_s(OFS_IMR)
        |=> s.rsp.prdata == $past(s.imr))
        else $error("mask register read wrong");

    AST_SMR_PRIO: assert property (smr_wr_s
        |=> s.prio[$past(apb_req.paddr[6:2])] == $past(apb_req.pwdata[PRIO_LSB +: 3]))
        else $error("priority field not stored");

    AST_SMR_TYPE: assert property (smr_wr_s
        |=> s.stype[$past(apb_req.paddr[6:2])] == $past(apb_req.pwdata[TYPE_LSB +: 2]))
        else $error("trigger type field not stored");

    AST_SVR_STORE: assert property (svr_wr_s
        |=> s.svr[$past(apb_req.paddr[6:2])] == $past(apb_req.pwdata))
        else $error("handler address not stored");

    AST_ISR_NUM: assert property (rd_s(OFS_ISR) ##0 s.depth != 4'h0
        |=> s.rsp.prdata[4:0] == $past(s.stk[0][4:0]))
        else $error("current number not reported");

    // nothing above the level: no push, vector reads as zero
    AST_IVR_NONE: assert property (rd_s(OFS_IVR) ##0 !above
        |=> s.depth == $past(s.depth) && s.rsp.prdata == RST_WORD)
        else $error("vector read with nothing above level changed state");

    AST_EOI_REASSERT: assert property (eoi_pop_s ##1 above
        |=> !s.irq_n)
        else $error("normal request not raised after pop");

    // ****************************************
    // fast path checks
    // ****************************************
    AST_FVR_CLR: assert property (fvr_take_s
        ##0 (is_edge(s.stype[0]) && !(|(s.ffsr & NRM_MASK)) && !edge_hit[0])
        |=> !s.edge_pend[0])
        else $error("edge fast source not cleared by fast vector read");

    AST_FAST0: assert property (s.imr[0] && pend[0] |=> !s.fiq_n)
        else $error("enabled source 0 did not raise fast request");

    AST_FIQ_IDLE: assert property (!(s.imr[0] && pend[0])
        && (pend & s.imr & s.ffsr & NRM_MASK) == 32'h0000_0000 |=> s.fiq_n)
        else $error("fast request without a fast contributor");

    // ****************************************
    // forcing checks
    // ****************************************
    // bit 0 of the force register is held at zero
    AST_FF_SRC0: assert property (!s.ffsr[0])
        else $error("source 0 marked as forced");

    AST_FFER: assert property (wr_s(OFS_FFER)
        |=> (s.ffsr & $past(apb_req.pwdata) & NRM_MASK) == ($past(apb_req.pwdata) & NRM_MASK))
        else $error("force enable bits not set");

    AST_FFDR: assert property (wr_s(OFS_FFDR)
        |=> (s.ffsr & $past(apb_req.pwdata)) == 32'h0000_0000)
        else $error("force disable bits not cleared");

    // forced sources alone must leave the normal line idle
    AST_FORCE_NO_IRQ: assert property (
        (pend & s.imr & ~s.ffsr & NRM_MASK) == 32'h0000_0000 |=> s.irq_n)
        else $error("normal request without a non-forced source");

    AST_FORCE_FIQ: assert property (|(pend & s.imr & s.ffsr & NRM_MASK)
        |=> !s.fiq_n)
        else $error("forced source did not raise fast request");

    AST_FF_PEND0: assert property (wr_s(OFS_FFER) ##0 !edge_hit[0]
        |=> s.edge_pend[0] == $past(s.edge_pend[0]))
        else $error("forcing changed source 0 pending bit");

    AST_IVR_KEEP_FORCED: assert property (rd_s(OFS_IVR)
        |=> ($past(s.edge_pend & s.ffsr) & ~s.edge_pend) == 32'h0000_0000)
        else $error("vector read cleared a forced source");
endmodule
